// [vga_regs_cfg.svh]
// offsets, field positions, reset values and codes for the general registers
`ifndef VGA_REGS_CFG_SVH
`define VGA_REGS_CFG_SVH

`define MISC_WR_ADDR        16'h03c2
`define MISC_RD_ADDR        16'h03cc
`define STAT0_ADDR          16'h03c2
`define SEQ_INDEX_ADDR      16'h03c4
`define SEQUENCER_DATA_PORT_ADDR       16'h03c5
`define FEAT_RD_ADDR        16'h03ca
`define FEAT_WR_LO          8'hda
`define STAT1_LO            8'hda
`define COLOR_BASE          12'h03d
`define MONO_BASE           12'h03b

`define MISC_RESET          8'h00
`define FEAT_RESET          8'h00
`define SEQ_INDEX_RESET     5'h00
`define LEGACY_RST_RESET    2'h0
`define SEQ_IDX_LEGACY      5'h00
`define SEQ_IDX_PLL_A       5'h12
`define SEQ_IDX_PLL_B       5'h13
`define SEQ_IDX_EXT_CTL     5'h15

`define MISC_IOSEL_BIT      0
`define MISC_VRAM_BIT       1
`define MISC_CLK_LO         2
`define MISC_PAGE_BIT       5
`define MISC_HSP_BIT        6
`define MISC_VSP_BIT        7
`define FEAT_VSYNC_TYPE_SELECT_BIT       3
`define EXT_PRESET_BIT      1
`define FEAT_MASK           8'h08
`define MISC_MASK           8'hef

`define PLL_A_25M           8'h00
`define PLL_B_25M           8'h00
`define PLL_A_28M           8'h00
`define PLL_B_28M           8'h00
`define CPE_PAIR_LO         4

`endif

// [vga_regs_pkg.sv]
// types shared by the general register bank
package vga_regs_pkg;
    typedef enum logic [1:0] {
        clk_25m,
        clk_28m,
        clk_reserved,
        clk_program
    } clk_sel_t;
endpackage

// [sync_two_ff.sv]
// two flip-flop synchroniser, one per bit
`timescale 1ns/1ns
module sync_two_ff #(
    parameter int WIDTH = 1
) (
    input  wire logic             core_clk_i,
    input  wire logic             rst_n_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] sync_next;

    always_comb begin
        meta_next = async_i;
        sync_next = meta_reg;
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_reg <= '0;
            sync_o   <= '0;
        end else begin
            meta_reg <= meta_next;
            sync_o   <= sync_next;
        end
    end
endmodule

// [vga_general_and_sequencer_regs.sv]
// general output/status registers and sequencer index/data port
//
// How it works
// RQ1: io_base_select picks 3Dx (1) or 3Bx (0) for the crt-group ports.
// RQ2: hardware reset clears the misc output control register.
// RQ3: host video memory access allowed only while misc bit 1 is set.
// RQ4: clock-select field decodes 25.175, 28.322, reserved, or pll load.
// RQ5: writing code 00 or 01 with preset enable loads pll presets.
// RQ6: high_page_select maps host accesses to the high 64K page.
// RQ7: polarity bits 6 and 7 invert horizontal and vertical sync.
// RQ8: vsync_type_select ORs vertical sync with vertical display enable.
// RQ9: input status zero bit 4 returns the monitor sense level.
// RQ10: input status zero bit 7 shows a pending retrace interrupt.
// RQ11: input status one bit 0 is set during any retrace.
// RQ12: input status one bit 3 is set during vertical retrace.
// RQ13: status one bits 5-4 return two colour outputs chosen by plane enable.
// RQ14: host writes index to 3C4 then accesses data at 3C5.
// RQ15: sequencer index is five bits, upper three reserved.
// RQ16: legacy reset bits are stored only and have no effect.
// RQ17: host writes zero to reserved bits; reads return zero here, except status one bit 2, which reads one.
// RQ18: sequencer index register resets to zero.
`timescale 1ns/1ns
`include "vga_regs_cfg.svh"
module vga_general_and_sequencer_regs (
    // clock and reset
    input  wire logic                   core_clk_i,
    input  wire logic                   rst_n_i,
    // host i/o port
    input  wire logic [15:0]            io_addr_i,
    input  wire logic                   io_wr_i,
    input  wire logic                   io_rd_i,
    input  wire logic [7:0]             io_wdata_i,
    output logic      [7:0]             io_rdata_o,
    output logic                        io_hit_o,
    // crt group decode
    output logic      [11:0]            crt_base_o,
    // video memory control
    input  wire logic                   vram_req_i,
    output logic                        vram_grant_o,
    output logic                        high_page_select_o,
    // dot clock control
    output logic      [1:0]             dot_clock_sel_o,
    output logic                        pll_param_load_en_o,
    output logic                        pll_preset_wr_o,
    output logic      [7:0]             pll_param_reg_a_o,
    output logic      [7:0]             pll_param_reg_b_o,
    // sync from crt timing, same clock
    input  wire logic                   hsync_raw_i,
    input  wire logic                   vsync_raw_i,
    input  wire logic                   vert_display_en_i,
    input  wire logic                   horiz_retrace_i,
    input  wire logic                   vert_retrace_i,
    input  wire logic                   retrace_irq_pending_i,
    output logic                        hsync_o,
    output logic                        vsync_o,
    // attribute controller feedback
    input  wire logic [7:0]             color_out_i,
    input  wire logic [1:0]             color_plane_enable_i,
    // monitor sense pin
    input  wire logic                   monitor_sense_pin_i,
    // sequencer data to other sequencer registers
    output logic      [4:0]             seq_index_o,
    output logic                        seq_ext_wr_o,
    output logic      [7:0]             seq_ext_wdata_o,
    input  wire logic [7:0]             seq_ext_rdata_i
);
    import vga_regs_pkg::*;

    // stored register fields
    logic [7:0] misc_output_control_reg;
    logic [7:0] misc_output_control_next;
    logic [7:0] feature_control_reg;
    logic [7:0] feature_control_next;
    logic [4:0] seq_index_field_reg;
    logic [4:0] seq_index_field_next;
    logic [1:0] legacy_sequencer_reset_reg;
    logic [1:0] legacy_sequencer_reset_next;
    logic [7:0] ext_sequencer_control_reg;
    logic [7:0] ext_sequencer_control_next;
    logic [7:0] pll_a_reg;
    logic [7:0] pll_a_next;
    logic [7:0] pll_b_reg;
    logic [7:0] pll_b_next;

    // next values of the registered outputs
    logic [7:0] rdata_next;
    logic       hit_next;
    logic       hsync_next;
    logic       vsync_next;
    logic       grant_next;
    logic       preset_next;
    logic       ext_wr_next;
    logic [11:0] crt_base_next;
    logic       load_en_next;

    // decoded status words and addresses
    logic       monitor_sense_level;
    logic [11:0] crt_base;
    logic [7:0] input_status_zero;
    logic [7:0] input_status_one;
    logic [1:0] video_feedback_bits;
    logic [15:0] stat1_addr;
    logic [15:0] feat_wr_addr;

    // one-cycle access strobes
    logic       wr_misc;
    logic       wr_feat;
    logic       wr_index;
    logic       wr_data;

    // clock-select codes, stored and being written
    clk_sel_t   clk_sel;
    clk_sel_t   new_clk_sel;

    // pin level is asynchronous to the core clock
    sync_two_ff #(
        .WIDTH (1)
    ) u_sense_sync (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .async_i    (monitor_sense_pin_i),
        .sync_o     (monitor_sense_level)
    );

    always_comb begin
        // RQ1: crt-group base select
        crt_base = misc_output_control_reg[`MISC_IOSEL_BIT] ?
                   `COLOR_BASE : `MONO_BASE;
        stat1_addr   = {crt_base, 4'h0} | {8'h00, `STAT1_LO & 8'h0f};
        feat_wr_addr = {crt_base, 4'h0} | {8'h00, `FEAT_WR_LO & 8'h0f};
        wr_misc  = io_wr_i && io_addr_i == `MISC_WR_ADDR;
        // feature write shares its port with the status one read
        wr_feat  = io_wr_i && io_addr_i == feat_wr_addr;
        // RQ14: index then data port
        wr_index = io_wr_i && io_addr_i == `SEQ_INDEX_ADDR;
        wr_data  = io_wr_i && io_addr_i == `SEQUENCER_DATA_PORT_ADDR;
        new_clk_sel = clk_sel_t'(io_wdata_i[`MISC_CLK_LO +: 2]);
        // RQ13: feedback pair chosen by plane enable bits
        video_feedback_bits = color_out_i[2*color_plane_enable_i +: 2];
        // RQ9: monitor sense; RQ10: pending retrace irq
        input_status_zero = {retrace_irq_pending_i, 2'b00,
                             monitor_sense_level, 4'h0};
        // bit 2 always reads one and bit 1 zero
        // RQ11: retrace of either kind; RQ12: vertical retrace
        input_status_one = {2'b00, video_feedback_bits,
                            vert_retrace_i, 1'b1, 1'b0,
                            horiz_retrace_i | vert_retrace_i};
    end

    always_comb begin
        misc_output_control_next    = misc_output_control_reg;
        feature_control_next        = feature_control_reg;
        seq_index_field_next        = seq_index_field_reg;
        legacy_sequencer_reset_next = legacy_sequencer_reset_reg;
        ext_sequencer_control_next  = ext_sequencer_control_reg;
        pll_a_next  = pll_a_reg;
        pll_b_next  = pll_b_reg;
        preset_next = 1'b0;
        ext_wr_next = 1'b0;
        // RQ17: reserved bits are not stored
        if (wr_misc) begin
            misc_output_control_next = io_wdata_i & `MISC_MASK;
        end
        if (wr_feat) begin
            feature_control_next = io_wdata_i & `FEAT_MASK;
        end
        // RQ15: five-bit index field
        if (wr_index) begin
            seq_index_field_next = io_wdata_i[4:0];
        end
        // indexes not held here go out on the ext write strobe
        if (wr_data) begin
            if (seq_index_field_reg == `SEQ_IDX_LEGACY) begin
                // RQ16: stored only, no reset action
                legacy_sequencer_reset_next = io_wdata_i[1:0];
            end else if (seq_index_field_reg == `SEQ_IDX_EXT_CTL) begin
                ext_sequencer_control_next = io_wdata_i;
            end else if (seq_index_field_reg == `SEQ_IDX_PLL_A) begin
                pll_a_next = io_wdata_i;
            end else if (seq_index_field_reg == `SEQ_IDX_PLL_B) begin
                pll_b_next = io_wdata_i;
            end else begin
                ext_wr_next = 1'b1;
            end
        end
        // RQ5: preset load on clock-select write
        // same edge as the misc write, so the pair never lags the code
        if (wr_misc && ext_sequencer_control_reg[`EXT_PRESET_BIT]) begin
            if (new_clk_sel == clk_25m) begin
                pll_a_next  = `PLL_A_25M;
                pll_b_next  = `PLL_B_25M;
                preset_next = 1'b1;
            end else if (new_clk_sel == clk_28m) begin
                pll_a_next  = `PLL_A_28M;
                pll_b_next  = `PLL_B_28M;
                preset_next = 1'b1;
            end
        end
        // taken from the next value so the pins move with the register
        // RQ1: crt base follows the io select bit being written
        crt_base_next = misc_output_control_next[`MISC_IOSEL_BIT] ?
                        `COLOR_BASE : `MONO_BASE;
        // RQ4: code 11 enables pll parameter loading
        clk_sel = clk_sel_t'(misc_output_control_next[`MISC_CLK_LO +: 2]);
        load_en_next = clk_sel == clk_program;
    end

    always_comb begin
        rdata_next = 8'h00;
        // every decoded access, write or read, answers one cycle later
        hit_next   = 1'b1;
        if (io_rd_i && io_addr_i == `MISC_RD_ADDR) begin
            rdata_next = misc_output_control_reg;
        end else if (io_rd_i && io_addr_i == `STAT0_ADDR) begin
            rdata_next = input_status_zero;
        end else if (io_rd_i && io_addr_i == `FEAT_RD_ADDR) begin
            rdata_next = feature_control_reg;
        end else if (io_rd_i && io_addr_i == stat1_addr) begin
            rdata_next = input_status_one;
        end else if (io_rd_i && io_addr_i == `SEQ_INDEX_ADDR) begin
            rdata_next = {3'b000, seq_index_field_reg};
        // unknown indexes are answered by the outer sequencer
        end else if (io_rd_i && io_addr_i == `SEQUENCER_DATA_PORT_ADDR) begin
            if (seq_index_field_reg == `SEQ_IDX_LEGACY) begin
                rdata_next = {6'h00, legacy_sequencer_reset_reg};
            end else if (seq_index_field_reg == `SEQ_IDX_EXT_CTL) begin
                rdata_next = ext_sequencer_control_reg;
            end else if (seq_index_field_reg == `SEQ_IDX_PLL_A) begin
                rdata_next = pll_a_reg;
            end else if (seq_index_field_reg == `SEQ_IDX_PLL_B) begin
                rdata_next = pll_b_reg;
            end else begin
                rdata_next = seq_ext_rdata_i;
            end
        end else if (wr_misc || wr_feat || wr_index || wr_data) begin
            rdata_next = 8'h00;
        end else begin
            hit_next = 1'b0;
        end
        // both syncs pass one register so they stay aligned
        // RQ7: sync polarity
        hsync_next = hsync_raw_i ^ misc_output_control_reg[`MISC_HSP_BIT];
        // RQ8: vsync type select
        vsync_next = (feature_control_reg[`FEAT_VSYNC_TYPE_SELECT_BIT] ?
                      (vsync_raw_i | vert_display_en_i) : vsync_raw_i) ^
                     misc_output_control_reg[`MISC_VSP_BIT];
        // RQ3: gate host video memory access
        grant_next = vram_req_i & misc_output_control_reg[`MISC_VRAM_BIT];
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            // RQ2: clear misc on reset
            misc_output_control_reg    <= `MISC_RESET;
            feature_control_reg        <= `FEAT_RESET;
            // RQ18: defined index after reset
            seq_index_field_reg        <= `SEQ_INDEX_RESET;
            legacy_sequencer_reset_reg <= `LEGACY_RST_RESET;
            ext_sequencer_control_reg  <= 8'h00;
            pll_a_reg       <= 8'h00;
            pll_b_reg       <= 8'h00;
            io_rdata_o      <= 8'h00;
            io_hit_o        <= 1'b0;
            hsync_o         <= 1'b0;
            vsync_o         <= 1'b0;
            vram_grant_o    <= 1'b0;
            pll_preset_wr_o <= 1'b0;
            seq_ext_wr_o    <= 1'b0;
            seq_ext_wdata_o <= 8'h00;
            crt_base_o      <= `MONO_BASE;
            pll_param_load_en_o <= 1'b0;
        end else begin
            misc_output_control_reg    <= misc_output_control_next;
            feature_control_reg        <= feature_control_next;
            seq_index_field_reg        <= seq_index_field_next;
            legacy_sequencer_reset_reg <= legacy_sequencer_reset_next;
            ext_sequencer_control_reg  <= ext_sequencer_control_next;
            pll_a_reg       <= pll_a_next;
            pll_b_reg       <= pll_b_next;
            io_rdata_o      <= rdata_next;
            io_hit_o        <= hit_next;
            hsync_o         <= hsync_next;
            vsync_o         <= vsync_next;
            vram_grant_o    <= grant_next;
            pll_preset_wr_o <= preset_next;
            seq_ext_wr_o    <= ext_wr_next;
            // data registered every cycle; seq_ext_wr_o says when it counts
            seq_ext_wdata_o <= io_wdata_i;
            crt_base_o      <= crt_base_next;
            pll_param_load_en_o <= load_en_next;
        end
    end

    // control outputs are the registers themselves
    always_comb begin
        // RQ6: high 64K page select
        high_page_select_o  = misc_output_control_reg[`MISC_PAGE_BIT];
        dot_clock_sel_o     = misc_output_control_reg[`MISC_CLK_LO +: 2];
        pll_param_reg_a_o   = pll_a_reg;
        pll_param_reg_b_o   = pll_b_reg;
        seq_index_o         = seq_index_field_reg;
    end
endmodule

// [vga_regs_sva.sv]
// port assertions for the general register bank
`timescale 1ns/1ns
module vga_regs_sva (
    input wire logic        core_clk_i,
    input wire logic        rst_n_i,
    input wire logic [15:0] io_addr_i,
    input wire logic        io_wr_i,
    input wire logic        io_rd_i,
    input wire logic [7:0]  io_wdata_i,
    input wire logic [7:0]  io_rdata_o,
    input wire logic        io_hit_o,
    input wire logic [11:0] crt_base_o,
    input wire logic        vram_req_i,
    input wire logic        vram_grant_o,
    input wire logic        high_page_select_o,
    input wire logic [1:0]  dot_clock_sel_o,
    input wire logic        pll_param_load_en_o,
    input wire logic        pll_preset_wr_o,
    input wire logic        hsync_raw_i,
    input wire logic        vsync_raw_i,
    input wire logic        vert_display_en_i,
    input wire logic        horiz_retrace_i,
    input wire logic        vert_retrace_i,
    input wire logic        retrace_irq_pending_i,
    input wire logic        hsync_o,
    input wire logic        vsync_o,
    input wire logic [7:0]  color_out_i,
    input wire logic [1:0]  color_plane_enable_i,
    input wire logic [4:0]  seq_index_o
);
    // shadows of the writable bits, rebuilt from host traffic
    logic [7:0] misc_reg;
    logic       feat_reg;
    logic       ext_reg;
    wire        mw = io_wr_i && io_addr_i == 16'h03c2;
    wire        pw = mw && !io_wdata_i[3] && ext_reg;
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            misc_reg <= 8'h00;
            feat_reg <= 1'b0;
            ext_reg <= 1'b0;
        end else begin
            if (mw) misc_reg <= io_wdata_i & 8'hef;
            if (io_wr_i && io_addr_i == {crt_base_o, 4'ha})
                feat_reg <= io_wdata_i[3];
            if (io_wr_i && io_addr_i == 16'h03c5 && seq_index_o == 5'h15)
                ext_reg <= io_wdata_i[1];
        end
    end
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    chk_crt_base: assert property (
        crt_base_o == (misc_reg[0] ? 12'h03d : 12'h03b)) else $error("bad base");
    chk_vram_gate: assert property ($past(rst_n_i) |->
        vram_grant_o == ($past(vram_req_i) && $past(misc_reg[1])))
        else $error("bad grant");
    chk_clock_select: assert property (dot_clock_sel_o == misc_reg[3:2]
        && pll_param_load_en_o == (misc_reg[3:2] == 2'b11)) else $error("clk");
    chk_preset_pulse: assert property ($past(rst_n_i) |->
        pll_preset_wr_o == $past(pw)) else $error("bad preset pulse");
    chk_page_select: assert property (
        high_page_select_o == misc_reg[5]) else $error("bad page");
    chk_hsync_pol: assert property ($past(rst_n_i) |->
        hsync_o == ($past(hsync_raw_i) ^ $past(misc_reg[6]))) else $error("hs");
    chk_vsync_type: assert property ($past(rst_n_i) |-> vsync_o ==
        ($past(feat_reg ? vsync_raw_i | vert_display_en_i : vsync_raw_i)
        ^ $past(misc_reg[7]))) else $error("bad vsync");
    chk_irq_status: assert property (io_rd_i && io_addr_i == 16'h03c2
        |=> io_rdata_o[7] == $past(retrace_irq_pending_i)) else $error("irq");
    chk_stat_one: assert property (io_rd_i &&
        io_addr_i == {crt_base_o, 4'ha} |=> io_rdata_o[5:0] ==
        {$past(color_out_i[{color_plane_enable_i, 1'b0} +: 2]),
        $past(vert_retrace_i), 2'b10, $past(horiz_retrace_i | vert_retrace_i)})
        else $error("bad status one");
    chk_index_store: assert property (io_wr_i && io_addr_i == 16'h03c4
        |=> seq_index_o == $past(io_wdata_i[4:0])) else $error("bad index");
    chk_data_hit: assert property ((io_rd_i || io_wr_i) &&
        io_addr_i == 16'h03c5 |=> io_hit_o) else $error("no hit on data port");
    chk_unmapped_quiet: assert property ((io_rd_i || io_wr_i) &&
        io_addr_i[15:8] != 8'h03 |=> !io_hit_o && io_rdata_o == 8'h00)
        else $error("unmapped answered");
    cov_preset: cover property (pll_preset_wr_o);
    cov_grant: cover property (vram_grant_o);
    cov_stat_one: cover property (io_rd_i && io_addr_i == {crt_base_o, 4'ha});
endmodule

// [host_io_model.sv]
// host processor model issuing i/o port cycles
`timescale 1ns/1ns
module host_io_model (
    input  wire logic        core_clk_i,
    input  wire logic [7:0]  rdata_i,
    input  wire logic        hit_i,
    output logic      [15:0] addr_o,
    output logic             wr_o,
    output logic             rd_o,
    output logic      [7:0]  wdata_o
);
    initial begin
        addr_o = 16'h0000;
        wr_o = 1'b0;
        rd_o = 1'b0;
        wdata_o = 8'h00;
    end
    // one byte cycle, held until its taking edge
    task automatic access(input logic w, input logic [15:0] a,
                          input logic [7:0] d, output logic [7:0] q,
                          output logic h);
        @(posedge core_clk_i);
        addr_o <= a;
        wr_o <= w;
        rd_o <= !w;
        wdata_o <= d;
        @(posedge core_clk_i);
        // released lines must not keep looking valid
        addr_o <= ~a;
        wdata_o <= ~d;
        wr_o <= 1'b0;
        rd_o <= 1'b0;
        @(negedge core_clk_i);
        q = rdata_i;
        h = hit_i;
    endtask
endmodule

// [tb_top.sv]
// self-checking bench for the general register bank
`timescale 1ns/1ns
`include "vga_regs_cfg.svh"
module tb_top;
    logic core_clk_i = 1'b0, rst_n_i = 1'b0;
    logic [15:0] io_addr_i;
    logic io_wr_i, io_rd_i, io_hit_o, vram_req_i, vram_grant_o;
    logic [7:0] io_wdata_i, io_rdata_o, color_out_i, seq_ext_rdata_i;
    logic [7:0] pll_param_reg_a_o, pll_param_reg_b_o, seq_ext_wdata_o, q, d;
    logic [11:0] crt_base_o;
    logic [1:0] dot_clock_sel_o, color_plane_enable_i;
    logic [4:0] seq_index_o;
    logic high_page_select_o, pll_param_load_en_o, pll_preset_wr_o, h;
    logic hsync_raw_i, vsync_raw_i, vert_display_en_i, horiz_retrace_i;
    logic vert_retrace_i, retrace_irq_pending_i, hsync_o, vsync_o;
    logic monitor_sense_pin_i, seq_ext_wr_o;
    integer seed = 32'hb261_70d5;
    int bad_count = 0, n_tests = 0;
    always #4 core_clk_i = ~core_clk_i;
    vga_general_and_sequencer_regs i_vga_general_and_sequencer_regs (.*);
    host_io_model i_host_io_model (.core_clk_i(core_clk_i),
        .rdata_i(io_rdata_o), .hit_i(io_hit_o), .addr_o(io_addr_i),
        .wr_o(io_wr_i), .rd_o(io_rd_i), .wdata_o(io_wdata_i));
    always @(posedge core_clk_i) begin
        {hsync_raw_i, vsync_raw_i, vert_display_en_i, horiz_retrace_i,
         vert_retrace_i, retrace_irq_pending_i, vram_req_i,
         color_plane_enable_i} <= 9'($random(seed));
        color_out_i <= 8'($random(seed));
        seq_ext_rdata_i <= 8'($random(seed));
    end
    // feature write and status one sit at 3DA or 3BA
    function automatic logic [15:0] fcr_addr(input logic [7:0] m);
        return m[0] ? 16'h03da : 16'h03ba;
    endfunction
    task automatic check(input logic [15:0] got, exp, input string msg);
        n_tests++;
        if (got !== exp) begin
            $display("MISMATCH t=%0t %s", $time, msg);
            bad_count++;
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        i_host_io_model.access(1'b1, a, v, q, h);
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e, string m);
        i_host_io_model.access(1'b0, a, 8'h00, q, h);
        check({7'h00, h, q}, {8'h01, e}, m);
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        monitor_sense_pin_i = 1'b0;
        repeat (8) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        rd(16'h03cc, 8'h00, "misc reset");
        rd(16'h03ca, 8'h00, "feature reset");
        rd(16'h03c4, 8'h00, "index reset");
        $display("reset test done");
        for (int i = 0; i < 40; i++) begin
            d = 8'($random(seed)) & 8'hef;
            wr(16'h03c2, d);
            rd(16'h03cc, d, "misc readback");
            wr(fcr_addr(d), d & 8'h08);
            rd(16'h03ca, d & 8'h08, "feature readback");
            i_host_io_model.access(1'b0, fcr_addr(d), 8'h00, q, h);
            check({15'h0, q[2]}, 16'h0001, "status one bit 2");
            i_host_io_model.access(1'b0, 16'h03c2, 8'h00, q, h);
            wr(16'h03c4, d & 8'h1f);
            rd(16'h03c4, d & 8'h1f, "index readback");
        end
        $display("random register test done");
        wr(16'h03c2, 8'h00);
        wr(16'h03c4, 8'h00);
        wr(16'h03c5, 8'h03);
        rd(16'h03c5, 8'h03, "legacy bits");
        rd(16'h03cc, 8'h00, "no side effect");
        wr(16'h03c4, 8'h15);
        wr(16'h03c5, 8'h02);
        wr(16'h03c4, 8'h12);
        wr(16'h03c5, 8'h5a);
        wr(16'h03c4, 8'h13);
        wr(16'h03c5, 8'ha5);
        check({pll_param_reg_a_o, pll_param_reg_b_o}, 16'h5aa5, "pll");
        for (int c = 0; c < 4; c++) begin
            wr(16'h03c2, {4'h0, 2'(c), 2'b00});
            check({14'h0, dot_clock_sel_o}, 16'(c), "clock code");
        end
        check(16'(pll_param_reg_a_o), 16'(`PLL_A_28M), "preset a");
        check(16'(pll_param_reg_b_o), 16'(`PLL_B_28M), "preset b");
        wr(16'h03c4, 8'h01);
        wr(16'h03c5, 8'hc3);
        check({7'h00, seq_ext_wr_o, seq_ext_wdata_o}, 16'h01c3, "ext");
        $display("clock select test done");
        for (int s = 0; s < 2; s++) begin
            @(posedge core_clk_i);
            monitor_sense_pin_i <= s[0];
            repeat (4) @(posedge core_clk_i);
            i_host_io_model.access(1'b0, 16'h03c2, 8'h00, q, h);
            check({15'h0, q[4]}, {15'h0, s[0]}, "sense level");
        end
        i_host_io_model.access(1'b0, 16'h02c2, 8'h00, q, h);
        check({7'h00, h, q}, 16'h0000, "unmapped read");
        $display("sense and unmapped test done");
        final_report;
    end
    initial begin
        #200000;
        bad_count++;
        final_report;
    end
endmodule
bind vga_general_and_sequencer_regs vga_regs_sva i_vga_regs_sva (.*);
